/* fpc_counter.sv */
// Purpose: live count, target, status byte and events of one fast pulse counter
// Assumes: host strobes are one-cycle pulses on clk; field pins are asynchronous
// Notes:   status byte lags the live count by one clock
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"

module fpc_counter
    import fpc_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // host holding words and commands
    input  wire logic [7:0]   counter_control_byte,
    input  wire logic [31:0]  pending_count_word,
    input  wire logic [31:0]  pending_target_word,
    input  wire logic         counter_program_cmd,
    input  wire logic         counter_define_cmd,
    input  wire logic [3:0]   define_mode,
    input  wire fpc_evt_type  event_enable,
    // field pins
    input  wire fpc_pins_type field_pins,
    // read path and events
    output logic [31:0]       live_count_read_path,
    output logic [7:0]        counter_flags,
    output fpc_evt_type       event_out,
    output logic              define_error
);

    fpc_state_type st_ff;
    fpc_state_type nxt_st;

    // ==================================================
    // next state
    always_comb begin
        logic         rst_act;
        logic         start_act;
        logic         run;
        logic [3:0]   rise;
        logic [3:0]   chg;
        logic         step_up;
        logic         step_dn;
        logic         prog;
        rst_act   = 1'b0;
        start_act = 1'b0;
        run       = 1'b0;
        rise      = 4'h0;
        chg       = 4'h0;
        step_up   = 1'b0;
        step_dn   = 1'b0;
        prog      = counter_program_cmd && st_ff.defined;
        nxt_st    = st_ff;

        // three-stage pin sampling; a level counts once stages two and three agree
        nxt_st.s1  = field_pins;
        nxt_st.s2  = st_ff.s1;
        nxt_st.s3  = st_ff.s2;
        nxt_st.flt = (st_ff.s2 & st_ff.s3) | (st_ff.flt & (st_ff.s2 ^ st_ff.s3));
        rise       = nxt_st.flt & ~st_ff.flt;
        chg        = nxt_st.flt ^ st_ff.flt;

        // input set per mode: none, reset, reset and start
        rst_act   = (st_ff.sub != `FPC_SUB_NONE)
                    && (st_ff.flt[`FPC_PIN_RST] ^ st_ff.rst_low);
        start_act = (st_ff.sub != `FPC_SUB_RST_START)
                    || (st_ff.flt[`FPC_PIN_START] ^ st_ff.start_low);
        run       = st_ff.enabled && st_ff.defined && start_act;

        case (st_ff.kind)
            FPC_SINGLE_INT: begin
                step_up = rise[`FPC_PIN_A] && st_ff.dir;
                step_dn = rise[`FPC_PIN_A] && !st_ff.dir;
            end
            FPC_SINGLE_EXT: begin
                step_up = rise[`FPC_PIN_A] && nxt_st.flt[`FPC_PIN_B];
                step_dn = rise[`FPC_PIN_A] && !nxt_st.flt[`FPC_PIN_B];
            end
            FPC_TWO_CLK: begin
                // simultaneous up and down edges cancel
                step_up = rise[`FPC_PIN_A] && !rise[`FPC_PIN_B];
                step_dn = rise[`FPC_PIN_B] && !rise[`FPC_PIN_A];
            end
            default: begin
                if (st_ff.rate_1x) begin
                    step_up = rise[`FPC_PIN_A] && !nxt_st.flt[`FPC_PIN_B];
                    step_dn = rise[`FPC_PIN_A] && nxt_st.flt[`FPC_PIN_B];
                end else if (chg[`FPC_PIN_A] ^ chg[`FPC_PIN_B]) begin
                    // both phases moving at once is a lost step, ignored
                    step_up = nxt_st.flt[`FPC_PIN_A] ^ st_ff.flt[`FPC_PIN_B];
                    step_dn = !step_up;
                end
            end
        endcase

        nxt_st.evt      = '0;
        nxt_st.def_err  = 1'b0;
        nxt_st.rst_prev = run && rst_act;
        if (run && rst_act) begin
            nxt_st.count = '0;
            nxt_st.evt.ext_reset = !st_ff.rst_prev && event_enable.ext_reset;
        end else if (run && (step_up || step_dn)) begin
            nxt_st.count = step_up ? st_ff.count + 32'h0000_0001
                                   : st_ff.count - 32'h0000_0001;
            if (st_ff.kind != FPC_SINGLE_INT) begin
                nxt_st.dir = step_up;
                nxt_st.evt.dir_change = (step_up != st_ff.dir)
                                        && event_enable.dir_change;
            end
        end
        nxt_st.evt.equal = (nxt_st.count != st_ff.count)
                           && (nxt_st.count == st_ff.target)
                           && event_enable.equal;

        // program command: loading suspends counting and events for this cycle
        if (prog) begin
            nxt_st.count    = st_ff.count;
            nxt_st.evt      = '0;
            nxt_st.rst_prev = st_ff.rst_prev;
            nxt_st.enabled  = counter_control_byte[`FPC_CTRL_ENABLE];
            if (counter_control_byte[`FPC_CTRL_DIR_WR]) begin
                nxt_st.dir = counter_control_byte[`FPC_CTRL_DIR_UP];
            end
            if (counter_control_byte[`FPC_CTRL_TGT_WR]) begin
                nxt_st.target = pending_target_word;
            end
            if (counter_control_byte[`FPC_CTRL_CNT_WR]) begin
                nxt_st.count = pending_count_word;
            end
        end

        // define command: once only, and only for known modes
        if (counter_define_cmd) begin
            if (st_ff.defined || (define_mode > `FPC_MODE_LAST)) begin
                nxt_st.def_err = 1'b1;
            end else begin
                nxt_st.defined   = 1'b1;
                nxt_st.kind      = fpc_kind_type'(2'(define_mode / `FPC_MODES_PER_KIND));
                nxt_st.sub       = 2'(define_mode % `FPC_MODES_PER_KIND);
                nxt_st.rst_low   = counter_control_byte[`FPC_CTRL_RST_LOW];
                nxt_st.start_low = counter_control_byte[`FPC_CTRL_START_LOW];
                nxt_st.rate_1x   = counter_control_byte[`FPC_CTRL_RATE_1X];
            end
        end

        // status byte; kept valid every cycle, not only during service
        nxt_st.flags = '0;
        nxt_st.flags[`FPC_STAT_DIR] = st_ff.dir;
        nxt_st.flags[`FPC_STAT_EQ]  = (st_ff.count == st_ff.target);
        nxt_st.flags[`FPC_STAT_GT]  = $signed(st_ff.count) > $signed(st_ff.target);
        nxt_st.flags[4:0] = `FPC_STAT_UNUSED;
    end

    // ==================================================
    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==================================================
    // outputs, all straight from the state register
    assign live_count_read_path = st_ff.count;
    assign counter_flags        = st_ff.flags;
    assign event_out            = st_ff.evt;
    assign define_error         = st_ff.def_err;

    // ==================================================
    // checks
    // the first edge after release still shows the reset byte, not a compare result
    a_flags_equal: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |->
        counter_flags[`FPC_STAT_EQ] == ($past(st_ff.count) == $past(st_ff.target)))
        else $error("equal flag does not match count and target");

    a_flags_greater: assert property (@(posedge clk) disable iff (reset)
        counter_flags[`FPC_STAT_GT] ==
        ($signed($past(st_ff.count)) > $signed($past(st_ff.target))))
        else $error("greater flag is not a signed compare");

    a_flags_direction: assert property (@(posedge clk) disable iff (reset)
        counter_flags[`FPC_STAT_DIR] == $past(st_ff.dir))
        else $error("direction flag does not follow direction");

    a_flags_unused_zero: assert property (@(posedge clk) disable iff (reset)
        counter_flags[4:0] == `FPC_STAT_UNUSED)
        else $error("unused status bits not zero");

    a_count_load: assert property (@(posedge clk) disable iff (reset)
        counter_program_cmd && st_ff.defined && counter_control_byte[`FPC_CTRL_CNT_WR]
        |=> live_count_read_path == $past(pending_count_word))
        else $error("count word not loaded by program command");

    a_define_once: assert property (@(posedge clk) disable iff (reset)
        counter_define_cmd && st_ff.defined
        |=> define_error && $stable(st_ff.kind) && $stable(st_ff.sub))
        else $error("second define not refused");

    a_reset_clears: assert property (@(posedge clk) disable iff (reset)
        st_ff.enabled && st_ff.defined && st_ff.sub != `FPC_SUB_NONE
        && (st_ff.flt[`FPC_PIN_RST] ^ st_ff.rst_low) && st_ff.sub != `FPC_SUB_RST_START
        && !counter_program_cmd
        |=> live_count_read_path == 32'h0000_0000)
        else $error("active reset did not clear count");

    a_start_freeze: assert property (@(posedge clk) disable iff (reset)
        st_ff.sub == `FPC_SUB_RST_START && !(st_ff.flt[`FPC_PIN_START] ^ st_ff.start_low)
        && !counter_program_cmd
        |=> $stable(live_count_read_path))
        else $error("count moved while start inactive");

    a_equal_event: assert property (@(posedge clk) disable iff (reset)
        event_out.equal |-> live_count_read_path == st_ff.target)
        else $error("equal event without equal count");

    a_no_dir_event: assert property (@(posedge clk) disable iff (reset)
        st_ff.kind == FPC_SINGLE_INT |=> !event_out.dir_change)
        else $error("direction event in internal direction mode");

    a_masked_event: assert property (@(posedge clk) disable iff (reset)
        !event_enable.equal && !event_enable.ext_reset
        |=> !event_out.equal && !event_out.ext_reset)
        else $error("disabled event source fired");

    a_reset_event_mode: assert property (@(posedge clk) disable iff (reset)
        event_out.ext_reset |-> st_ff.sub != `FPC_SUB_NONE)
        else $error("reset event in mode without reset input");

    a_prog_quiet: assert property (@(posedge clk) disable iff (reset)
        counter_program_cmd && st_ff.defined
        |=> event_out == 3'h0)
        else $error("event raised in a program cycle");

    a_dir_masked: assert property (@(posedge clk) disable iff (reset)
        !event_enable.dir_change |=> !event_out.dir_change)
        else $error("disabled direction event fired");

    a_bad_mode: assert property (@(posedge clk) disable iff (reset)
        counter_define_cmd && (define_mode > `FPC_MODE_LAST)
        |=> define_error)
        else $error("unknown mode not refused");

    a_reset_once: assert property (@(posedge clk) disable iff (reset)
        event_out.ext_reset |=> !event_out.ext_reset)
        else $error("reset event repeated while reset held");

    c_equal_hit: cover property (@(posedge clk) disable iff (reset) event_out.equal);
    c_ext_reset: cover property (@(posedge clk) disable iff (reset) event_out.ext_reset);
    c_dir_change: cover property (@(posedge clk) disable iff (reset) event_out.dir_change);
    c_define_err: cover property (@(posedge clk) disable iff (reset) define_error);

endmodule
`default_nettype wire

/* fpc_regs.svh */
// Purpose: bit positions and codes for the fast pulse counter
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// ==================================================
// control byte fields
`define FPC_CTRL_RST_LOW    0
`define FPC_CTRL_START_LOW  1
`define FPC_CTRL_RATE_1X    2
`define FPC_CTRL_DIR_UP     3
`define FPC_CTRL_DIR_WR     4
`define FPC_CTRL_TGT_WR     5
`define FPC_CTRL_CNT_WR     6
`define FPC_CTRL_ENABLE     7

// ==================================================
// status byte fields
`define FPC_STAT_DIR        5
`define FPC_STAT_EQ         6
`define FPC_STAT_GT         7
`define FPC_STAT_UNUSED     5'h00

// ==================================================
// mode decoding: mode = kind * 3 + input set
`define FPC_MODE_LAST       4'hB
`define FPC_MODES_PER_KIND  4'h3
`define FPC_SUB_NONE        2'h0
`define FPC_SUB_RST_START   2'h2

// ==================================================
// pin order inside the pin bundle
`define FPC_PIN_A           0
`define FPC_PIN_B           1
`define FPC_PIN_RST         2
`define FPC_PIN_START       3

`endif

/* fpc_pkg.sv */
// Purpose: shared types of the fast pulse counter
// Assumes: nothing
// Notes:   positions and codes live in fpc_regs.svh
package fpc_pkg;

    // ==================================================
    // field pins, ordered as the FPC_PIN_* positions
    typedef struct packed {
        logic start;
        logic rst;
        logic b;
        logic a;
    } fpc_pins_type;

    // ==================================================
    // interrupt sources: enables and event pulses
    typedef struct packed {
        logic dir_change;
        logic ext_reset;
        logic equal;
    } fpc_evt_type;

    // ==================================================
    // counting kinds, three modes each
    typedef enum logic [1:0] {
        FPC_SINGLE_INT,
        FPC_SINGLE_EXT,
        FPC_TWO_CLK,
        FPC_QUAD
    } fpc_kind_type;

    // ==================================================
    // whole state of the counter
    typedef struct packed {
        logic [3:0]   s1;
        logic [3:0]   s2;
        logic [3:0]   s3;
        logic [3:0]   flt;
        logic [31:0]  count;
        logic [31:0]  target;
        logic         dir;
        logic         enabled;
        logic         defined;
        fpc_kind_type kind;
        logic [1:0]   sub;
        logic         rst_low;
        logic         start_low;
        logic         rate_1x;
        logic         rst_prev;
        fpc_evt_type  evt;
        logic         def_err;
        logic [7:0]   flags;
    } fpc_state_type;

endpackage

/* fpc_field_model.sv */
// Purpose: field pin source standing in for the pulse wiring
// Assumes: pins change on the falling clock edge only
// Notes:   each level is held 6 clocks, so filter, count and event tally settle
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"

module fpc_field_model
    import fpc_pkg::*;
(
    // clock
    input  wire logic         clk,
    // field pins
    output fpc_pins_type      pins
);
    // ==================================================
    // pin control
    initial pins = '0;

    // a hold of a single clock would be swallowed by the input filter
    task automatic set_pin(input int idx, input logic val);
        @(negedge clk);
        pins[idx] = val;
        repeat (6) @(negedge clk);
    endtask

    task automatic pulse(input int idx);
        set_pin(idx, 1'b1);
        set_pin(idx, 1'b0);
    endtask
endmodule
`default_nettype wire

/* test_fpc_counter.sv */
// Purpose: self-checking bench of the fast pulse counter
// Assumes: inputs change on the falling edge; clk 200 MHz
// Notes:   event pulses are tallied by a monitor, then compared
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"

module test_fpc_counter
    import fpc_pkg::*;
;
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    logic [7:0]   ctrl = 8'h00;
    logic [31:0]  cnt_w = 32'h0;
    logic [31:0]  tgt_w = 32'h0;
    logic         prog = 1'b0;
    logic         def = 1'b0;
    logic [3:0]   mode = 4'h0;
    fpc_evt_type  evt_en = 3'h0;
    fpc_pins_type pins;
    logic [31:0]  count;
    logic [7:0]   flags;
    fpc_evt_type  evt;
    logic         derr;
    int           err_count = 0;
    int           n_compared = 0;
    int           n_eq, n_rst, n_dir, n_derr;

    always #2.5 clk = ~clk;

    fpc_counter fpc_counter_inst (
        .clk(clk), .reset(reset), .counter_control_byte(ctrl),
        .pending_count_word(cnt_w), .pending_target_word(tgt_w),
        .counter_program_cmd(prog), .counter_define_cmd(def),
        .define_mode(mode), .event_enable(evt_en), .field_pins(pins),
        .live_count_read_path(count), .counter_flags(flags),
        .event_out(evt), .define_error(derr)
    );

    fpc_field_model fpc_field_model_inst (.clk(clk), .pins(pins));

    // ==================================================
    // event tally
    always @(posedge clk) begin
        if (evt.equal === 1'b1) n_eq++;
        if (evt.ext_reset === 1'b1) n_rst++;
        if (evt.dir_change === 1'b1) n_dir++;
        if (derr === 1'b1) n_derr++;
    end

    // ==================================================
    // host access
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic do_reset();
        @(negedge clk);
        reset = 1'b1;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        {n_eq, n_rst, n_dir, n_derr} = '0;
    endtask

    task automatic define_cmd(input logic [3:0] m, input logic [7:0] c);
        @(negedge clk);
        ctrl = c;
        mode = m;
        def = 1'b1;
        @(negedge clk);
        def = 1'b0;
        // let the error pulse reach the tally
        repeat (2) @(negedge clk);
    endtask

    // waits until the status byte has caught up with the load
    task automatic program_cmd(input logic [7:0] c, input logic [31:0] cv, input logic [31:0] tv);
        @(negedge clk);
        ctrl = c;
        cnt_w = cv;
        tgt_w = tv;
        prog = 1'b1;
        @(negedge clk);
        prog = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==================================================
    // watchdog: the sequence needs well under 2000 clocks
    initial begin
        #20000;
        err_count++;
        tally_and_finish();
    end

    // ==================================================
    // sequence
    initial begin
        do_reset();
        check("reset count", 32'h0, count);
        check("reset flags", 32'h0, {24'h0, flags});
        program_cmd(8'hF8, 32'h5, 32'h5);
        check("program before define", 32'h0, count);
        evt_en = 3'h7;
        define_cmd(4'h0, 8'hF8);
        program_cmd(8'hF8, 32'hFFFFFFFD, 32'hFFFFFFFF);
        check("signed load", 32'hFFFFFFFD, count);
        check("flags up below", 32'h20, {24'h0, flags});
        fpc_field_model_inst.pulse(`FPC_PIN_A);
        fpc_field_model_inst.pulse(`FPC_PIN_A);
        check("count at target", 32'hFFFFFFFF, count);
        check("flags equal", 32'h60, {24'h0, flags});
        check("equal events", 32'h1, n_eq);
        fpc_field_model_inst.pulse(`FPC_PIN_A);
        check("flags signed greater", 32'hA0, {24'h0, flags});
        define_cmd(4'h3, 8'hF8);
        check("second define error", 32'h1, n_derr);
        fpc_field_model_inst.set_pin(`FPC_PIN_RST, 1'b1);
        check("mode 0 ignores reset pin", 32'h0, count);
        fpc_field_model_inst.set_pin(`FPC_PIN_RST, 1'b0);
        program_cmd(8'h80, 32'h64, 32'h64);
        check("no apply bits", 32'h0, count);
        check("target kept", 32'hA0, {24'h0, flags});
        evt_en = 3'h6;
        program_cmd(8'h90, 32'h0, 32'h0);
        fpc_field_model_inst.pulse(`FPC_PIN_A);
        check("count down", 32'hFFFFFFFF, count);
        check("flags down equal", 32'h40, {24'h0, flags});
        check("equal masked", 32'h1, n_eq);
        check("no dir event mode 0", 32'h0, n_dir);
        program_cmd(8'h00, 32'h0, 32'h0);
        fpc_field_model_inst.pulse(`FPC_PIN_A);
        check("disabled holds", 32'hFFFFFFFF, count);
        // second run: reset and start inputs
        do_reset();
        evt_en = 3'h7;
        define_cmd(4'h2, 8'hF8);
        program_cmd(8'hF8, 32'h7, 32'h64);
        fpc_field_model_inst.set_pin(`FPC_PIN_RST, 1'b1);
        check("reset without start", 32'h7, count);
        check("no reset event yet", 32'h0, n_rst);
        fpc_field_model_inst.set_pin(`FPC_PIN_START, 1'b1);
        check("start under reset clears", 32'h0, count);
        check("reset event", 32'h1, n_rst);
        fpc_field_model_inst.pulse(`FPC_PIN_A);
        check("held cleared", 32'h0, count);
        fpc_field_model_inst.set_pin(`FPC_PIN_RST, 1'b0);
        fpc_field_model_inst.pulse(`FPC_PIN_A);
        check("counts after reset", 32'h1, count);
        // third run: external direction pin
        do_reset();
        define_cmd(4'h3, 8'hF8);
        program_cmd(8'hF8, 32'h5, 32'h0);
        check("flags up greater", 32'hA0, {24'h0, flags});
        fpc_field_model_inst.pulse(`FPC_PIN_A);
        check("pin b low counts down", 32'h4, count);
        check("flags down greater", 32'h80, {24'h0, flags});
        check("dir change event", 32'h1, n_dir);
        tally_and_finish();
    end
endmodule
`default_nettype wire
